// >>> logic/fsv_consts.svh
// Purpose: named constants for the fault supervisor
// Assumes: 25 MHz clock
// Notes: definitions only
`ifndef FSV_CONSTS_SVH
`define FSV_CONSTS_SVH
// status byte bit positions
`define FSV_BIT_DMEM 0
`define FSV_BIT_PMEM 1
`define FSV_BIT_FILM 2
`define FSV_BIT_SENS 3
`define FSV_BIT_PWR 5
`define FSV_BIT_CARD 6
// fault index codes in priority order
`define FSV_F_PMEM 3'h0
`define FSV_F_DMEM 3'h1
`define FSV_F_FILM 3'h2
`define FSV_F_PWR 3'h3
`define FSV_F_OSC 3'h4
`define FSV_F_CARD 3'h5
`define FSV_F_NONE 3'h7
// alternation half period
`define FSV_ALT_MS 500
`define FSV_CLK_KHZ 25000
`define FSV_ALT_CYC (`FSV_ALT_MS * `FSV_CLK_KHZ)
// reset values
`define FSV_PEND_RST 6'h00
`define FSV_STAT_RST 8'h00
`endif

// >>> logic/fsv_pkg.sv
// Purpose: shared types for the fault supervisor
// Assumes: included constants header
// Notes: types only
package fsv_pkg;
	// raw fault detections, one per source
	typedef struct packed {
		logic card;
		logic osc;
		logic pwr;
		logic film;
		logic dmem;
		logic pmem;
	} fsv_det_s;
	// display selector
	typedef enum logic [1:0] {
		FSV_DISP_MEAS = 2'b00,
		FSV_DISP_MSG = 2'b01,
		FSV_DISP_HELD = 2'b10
	} fsv_disp_e;
	// panel outputs
	typedef struct packed {
		fsv_disp_e sel;
		logic [2:0] code;
	} fsv_panel_s;
endpackage : fsv_pkg

// >>> logic/fsv_sync.sv
// Purpose: three-stage input synchroniser
// Assumes: async input, one clock
// Notes: output changes when stages two and three agree
`timescale 1ns/1ps
module fsv_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// data
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] s1_q; // first stage, read only by s2
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	////////////////////////////////////////////////////////////
	// shift chain
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	// accept a level when the last two agree
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dout <= '0;
		end else if (s2_q == s3_q) begin
			dout <= s3_q;
		end
	end
endmodule : fsv_sync

// >>> logic/fsv_top.sv
// Purpose: fault supervisor top
// Assumes: fault detect lines come from other clock logic or pins
// Notes: reset models power cycle; card cleared by card_swap strobe
`timescale 1ns/1ps
`include "fsv_consts.svh"
module fsv_top #(
	parameter int ALT_CYC = `FSV_ALT_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// fault detections from self test (async levels)
	input wire fsv_pkg::fsv_det_s det,
	input wire logic sens_in_fail,
	// power-up memory test done and result
	input wire logic mtest_done,
	input wire logic mtest_fail,
	// operator and system
	input wire logic stop_key,
	input wire logic card_swap,
	input wire logic run_req,
	// panel
	output fsv_pkg::fsv_panel_s panel,
	// shutter and process
	output logic shutter_open,
	output logic run_en,
	output logic ops_inhibit,
	output logic film_check,
	// status
	output logic [7:0] status
);
	fsv_pkg::fsv_det_s det_s; // synchronised detections
	logic [1:0] misc_s; // synced stop key and card swap
	logic stop_q; // previous stop level
	logic card_q; // previous card swap level
	logic stop_p; // stop press pulse
	logic card_p; // card swap pulse
	logic [5:0] pend_q; // latched faults, bit order as struct
	logic [5:0] now_v; // live conditions
	logic [2:0] sel_d; // highest priority pending
	logic hard_v; // memory fault present
	logic run_q; // run was active
	logic resume_q; // run to resume after power clear
	logic film_prev_q; // film latch one cycle back
	logic alt_q; // alternation phase, high shows held values
	logic [31:0] alt_cnt_q; // cycles into the current phase
	logic any_v; // some fault latched
	////////////////////////////////////////////////////////////
	// input synchronisers
	fsv_sync #(.W(6)) u_sync_det (
		.clk(clk),
		.rst_b(rst_b),
		.din(det),
		.dout(det_s)
	);
	fsv_sync #(.W(2)) u_sync_misc (
		.clk(clk),
		.rst_b(rst_b),
		.din({card_swap, stop_key}),
		.dout(misc_s)
	);
	// priority pick, used for display selection
	function automatic logic [2:0] pick(input logic [5:0] p);
		logic [2:0] r;
		r = `FSV_F_NONE;
		for (int i = 5; i >= 0; i--) begin
			if (p[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : pick
	////////////////////////////////////////////////////////////
	// edge detect on synced keys
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			stop_q <= 1'b0;
			card_q <= 1'b0;
		end else begin
			stop_q <= misc_s[0];
			card_q <= misc_s[1];
		end
	end
	// one-cycle press and swap pulses
	assign stop_p = misc_s[0] & ~stop_q;
	assign card_p = misc_s[1] & ~card_q;
	// live conditions, shown fault and memory lock
	assign now_v = det_s;
	assign sel_d = pick(pend_q);
	assign hard_v = pend_q[`FSV_F_PMEM] | pend_q[`FSV_F_DMEM];
	assign any_v = |pend_q;
	////////////////////////////////////////////////////////////
	// fault latches; set wins over clear
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pend_q <= `FSV_PEND_RST;
		end else begin
			for (int i = 0; i < 6; i++) begin
				if (now_v[i]) begin
					pend_q[i] <= 1'b1;
				end else if (i == int'(`FSV_F_CARD) && card_p) begin
					pend_q[i] <= 1'b0;
				end else if (stop_p && !hard_v && sel_d == 3'(i)
					&& i >= int'(`FSV_F_FILM) && i <= int'(`FSV_F_OSC)) begin
					pend_q[i] <= 1'b0;
				end
			end
			// power-up memory test result
			if (mtest_done && mtest_fail) begin
				pend_q[`FSV_F_DMEM] <= 1'b1;
			end
			// memory faults never clear here
		end
	end
	////////////////////////////////////////////////////////////
	// alternation timer for clearable faults
	always_ff @(posedge clk) begin
		if (!rst_b || !any_v || hard_v) begin
			alt_cnt_q <= '0;
			alt_q <= 1'b0;
		end else if (alt_cnt_q >= 32'(ALT_CYC - 1)) begin
			alt_cnt_q <= '0;
			alt_q <= ~alt_q;
		end else begin
			alt_cnt_q <= alt_cnt_q + 32'h00000001;
		end
	end
	////////////////////////////////////////////////////////////
	// display selection
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			panel <= '{sel: fsv_pkg::FSV_DISP_MEAS, code: `FSV_F_NONE};
		end else if (hard_v) begin
			panel <= '{sel: fsv_pkg::FSV_DISP_MSG, code: sel_d};
		end else if (any_v) begin
			panel.code <= sel_d;
			panel.sel <= alt_q ? fsv_pkg::FSV_DISP_HELD : fsv_pkg::FSV_DISP_MSG;
		end else begin
			panel <= '{sel: fsv_pkg::FSV_DISP_MEAS, code: `FSV_F_NONE};
		end
	end
	////////////////////////////////////////////////////////////
	// run tracking and power resume
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			run_q <= 1'b0;
			resume_q <= 1'b0;
		end else begin
			if (now_v[`FSV_F_PWR] && run_q) begin
				resume_q <= 1'b1;
			end else if (!any_v && run_req) begin
				// resume holds the run until the process request is back
				resume_q <= 1'b0;
			end
			if (any_v) begin
				run_q <= run_q; // held through faults
			end else begin
				run_q <= run_req | resume_q;
			end
		end
	end
	////////////////////////////////////////////////////////////
	// shutter, run enable, inhibit
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			shutter_open <= 1'b0;
			run_en <= 1'b0;
			ops_inhibit <= 1'b0;
		end else begin
			shutter_open <= !any_v && !(|now_v) && (run_req | resume_q);
			run_en <= !any_v && !(|now_v) && (run_req | resume_q);
			ops_inhibit <= hard_v | now_v[`FSV_F_PMEM] | now_v[`FSV_F_DMEM];
		end
	end
	////////////////////////////////////////////////////////////
	// film data check pulse on new film fault
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			film_prev_q <= 1'b0;
			film_check <= 1'b0;
		end else begin
			film_prev_q <= pend_q[`FSV_F_FILM];
			film_check <= pend_q[`FSV_F_FILM] & ~film_prev_q;
		end
	end
	////////////////////////////////////////////////////////////
	// status byte
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			status <= `FSV_STAT_RST;
		end else begin
			status <= `FSV_STAT_RST;
			status[`FSV_BIT_DMEM] <= pend_q[`FSV_F_DMEM];
			status[`FSV_BIT_PMEM] <= pend_q[`FSV_F_PMEM];
			status[`FSV_BIT_FILM] <= pend_q[`FSV_F_FILM];
			status[`FSV_BIT_SENS] <= sens_in_fail;
			status[`FSV_BIT_PWR] <= pend_q[`FSV_F_PWR];
			status[`FSV_BIT_CARD] <= pend_q[`FSV_F_CARD];
		end
	end
	////////////////////////////////////////////////////////////
	// assertions
	sequence s_stop_clear;
		stop_p && !hard_v && sel_d == `FSV_F_OSC && !now_v[`FSV_F_OSC];
	endsequence
	property p_mem_latch;
		@(posedge clk) disable iff (!rst_b) hard_v |=> hard_v;
	endproperty
	a_mem_latch: assert property (p_mem_latch) else $error("memory fault dropped");
	property p_hard_steady;
		@(posedge clk) disable iff (!rst_b) hard_v |=> panel.sel == fsv_pkg::FSV_DISP_MSG;
	endproperty
	a_hard_steady: assert property (p_hard_steady) else $error("memory msg not steady");
	property p_inhibit;
		@(posedge clk) disable iff (!rst_b) hard_v |=> ops_inhibit;
	endproperty
	a_inhibit: assert property (p_inhibit) else $error("ops not inhibited");
	property p_shut;
		@(posedge clk) disable iff (!rst_b) any_v |=> !shutter_open && !run_en;
	endproperty
	a_shut: assert property (p_shut) else $error("shutter open under fault");
	property p_osc_clear;
		@(posedge clk) disable iff (!rst_b) s_stop_clear |=> !pend_q[`FSV_F_OSC];
	endproperty
	a_osc_clear: assert property (p_osc_clear) else $error("osc not cleared");
	property p_idle;
		@(posedge clk) disable iff (!rst_b) !any_v |=> panel.sel != fsv_pkg::FSV_DISP_HELD;
	endproperty
	a_idle: assert property (p_idle) else $error("held values with no fault");
	property p_card;
		@(posedge clk) disable iff (!rst_b) pend_q[`FSV_F_CARD] && !card_p |=> pend_q[`FSV_F_CARD];
	endproperty
	a_card: assert property (p_card) else $error("card fault dropped");
	property p_stat;
		@(posedge clk) disable iff (!rst_b) pend_q[`FSV_F_PMEM] |=> status[`FSV_BIT_PMEM];
	endproperty
	a_stat: assert property (p_stat) else $error("status bit missing");
	////////////////////////////////////////////////////////////
	// detection and latching
	property p_pmem_set;
		@(posedge clk) disable iff (!rst_b) now_v[`FSV_F_PMEM] |=> pend_q[`FSV_F_PMEM];
	endproperty
	a_pmem_set: assert property (p_pmem_set) else $error("pmem fault not latched");
	property p_dmem_shut;
		@(posedge clk) disable iff (!rst_b)
			pend_q[`FSV_F_DMEM] |=> !shutter_open && status[`FSV_BIT_DMEM];
	endproperty
	a_dmem_shut: assert property (p_dmem_shut) else $error("dmem fault not shown");
	property p_mtest;
		@(posedge clk) disable iff (!rst_b) mtest_done && mtest_fail |=> pend_q[`FSV_F_DMEM];
	endproperty
	a_mtest: assert property (p_mtest) else $error("memory test fail lost");
	property p_film_pulse;
		@(posedge clk) disable iff (!rst_b) $rose(pend_q[`FSV_F_FILM]) |=> film_check;
	endproperty
	a_film_pulse: assert property (p_film_pulse) else $error("film check not started");
	////////////////////////////////////////////////////////////
	// display and run
	property p_no_run;
		@(posedge clk) disable iff (!rst_b) (any_v || (|now_v)) |=> !run_en;
	endproperty
	a_no_run: assert property (p_no_run) else $error("run allowed under fault");
	property p_soft_show;
		@(posedge clk) disable iff (!rst_b)
			any_v && !hard_v |=> panel.sel != fsv_pkg::FSV_DISP_MEAS;
	endproperty
	a_soft_show: assert property (p_soft_show) else $error("clearable fault not shown");
	property p_prio;
		@(posedge clk) disable iff (!rst_b) pend_q[`FSV_F_PMEM] |=> panel.code == `FSV_F_PMEM;
	endproperty
	a_prio: assert property (p_prio) else $error("priority order broken");
	property p_idle_code;
		@(posedge clk) disable iff (!rst_b) !any_v |=> panel.code == `FSV_F_NONE;
	endproperty
	a_idle_code: assert property (p_idle_code) else $error("fault code with no fault");
	////////////////////////////////////////////////////////////
	// operator clear
	sequence s_soft_clear;
		stop_p && !hard_v && sel_d >= `FSV_F_FILM && sel_d <= `FSV_F_OSC && !now_v[sel_d];
	endsequence
	property p_next;
		@(posedge clk) disable iff (!rst_b) s_soft_clear |=> sel_d != $past(sel_d);
	endproperty
	a_next: assert property (p_next) else $error("next fault not presented");
	property p_card_stop;
		@(posedge clk) disable iff (!rst_b)
			stop_p && !card_p && sel_d == `FSV_F_CARD |=> pend_q[`FSV_F_CARD];
	endproperty
	a_card_stop: assert property (p_card_stop) else $error("stop cleared card fault");
endmodule : fsv_top

// >>> tb/fsv_panel_model.sv
// Purpose: front panel stop key; display/shutter inputs are taken but not used
// Assumes: one clock, press request from the bench
// Notes: holds the key long enough to pass the input synchroniser
`timescale 1ns/1ps
module fsv_panel_model (
	// clock
	input wire logic clk,
	// bench request to press the key
	input wire logic press,
	// panel side seen by the operator
	input wire fsv_pkg::fsv_panel_s panel,
	input wire logic shutter_open,
	// key level to the block
	output logic stop_key
);
	int hold_cnt = 0; // cycles left with the key down
	////////////////////////////////////////////////////////////////
	// operator press: key down six cycles, then released low
	always @(posedge clk) begin
		if (press && hold_cnt == 0) begin
			hold_cnt <= 6;
		end else if (hold_cnt > 0) begin
			hold_cnt <= hold_cnt - 1;
		end
		stop_key <= #1 (hold_cnt > 1) || (press && hold_cnt == 0);
	end
endmodule : fsv_panel_model

// >>> tb/fsv_top_tb.sv
// Purpose: self-checking bench for the fault supervisor
// Assumes: 25 MHz clock, ALT_CYC of 4
// Notes: expectations queued by the driver, compared by a monitor
`timescale 1ns/1ps
module fsv_top_tb;
	logic clk = 1'b0, rst_b = 1'b0, sens_in_fail = 1'b0, mtest_done = 1'b0, mtest_fail = 1'b0;
	logic card_swap = 1'b0, run_req = 1'b0, press = 1'b0, stop_key, shutter_open;
	logic run_en, ops_inhibit, film_check, s;
	logic [7:0] status;
	logic [1:0] s0;
	fsv_pkg::fsv_det_s det = '0;
	fsv_pkg::fsv_panel_s panel;
	logic [31:0] q[$]; // mask and expected value pairs
	event smp; // a result is ready to compare
	int mismatches = 0, total_checks = 0, fc = 0, seed = 32'h5785;
	localparam logic [15:0] M_SEL = 16'hC000, M_CODE = 16'h3800, M_INH = 16'h0400;
	localparam logic [15:0] M_RUN = 16'h0200, M_SH = 16'h0100, M_ST = 16'h00FF;
	wire logic [15:0] obs = {panel, ops_inhibit, run_en, shutter_open, status};
	always #20 clk = ~clk;
	fsv_top #(.ALT_CYC(4)) DUT (.clk(clk), .rst_b(rst_b), .det(det), .sens_in_fail(sens_in_fail),
		.mtest_done(mtest_done), .mtest_fail(mtest_fail), .stop_key(stop_key),
		.card_swap(card_swap), .run_req(run_req), .panel(panel), .shutter_open(shutter_open),
		.run_en(run_en), .ops_inhibit(ops_inhibit), .film_check(film_check), .status(status));
	fsv_panel_model u_panel (.clk(clk), .press(press), .panel(panel),
		.shutter_open(shutter_open), .stop_key(stop_key));
	////////////////////////////////////////////////////////////////
	// shared helpers
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task look(input logic [15:0] m, input logic [15:0] v);
		q.push_back({m, v});
		->smp;
		step(1);
	endtask : look
	task push_stop;
		press = 1'b1;
		step(1);
		press = 1'b0;
		step(14);
	endtask : push_stop
	function automatic logic [15:0] ov(input logic [2:0] c, input logic [7:0] st);
		return {2'h0, c, 3'h0, st};
	endfunction : ov
	task give_verdict;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////////
	// monitor: oldest note against the outputs
	always @(smp) begin
		logic [31:0] e;
		e = q.pop_front();
		chk("outputs", obs & e[31:16], e[15:0]);
	end
	always @(posedge clk) if (film_check === 1'b1) fc++; // film check pulses
	initial begin
		#(40 * 4000);
		mismatches++;
		give_verdict();
	end
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		step(12);
		rst_b = 1'b1;
		step(2);
		look(M_SEL | M_CODE | M_INH | M_ST, ov(3'h7, 8'h00));
		det.osc = 1'b1;
		step(10);
		look(M_CODE | M_SH | M_RUN, ov(3'h4, 8'h00));
		s0 = panel.sel;
		step(4);
		chk("alternation", {14'h0, panel.sel ^ s0}, 16'h0003);
		push_stop();
		look(M_CODE, ov(3'h4, 8'h00));
		det.osc = 1'b0;
		step(10);
		push_stop();
		look(M_SEL | M_CODE, ov(3'h7, 8'h00));
		run_req = 1'b1;
		step(10);
		look(M_RUN | M_SH, 16'h0300);
		det.pwr = 1'b1;
		step(10);
		look(M_CODE | M_RUN | M_SH | M_ST, ov(3'h3, 8'h20));
		det.pwr = 1'b0;
		run_req = 1'b0;
		step(10);
		push_stop();
		look(M_CODE | M_RUN | M_SH, ov(3'h7, 8'h00) | 16'h0300);
		s = 1'($random(seed));
		sens_in_fail = s;
		det.film = 1'b1;
		det.pwr = 1'b1;
		det.card = 1'b1;
		step(10);
		look(M_CODE | M_ST | M_SH, ov(3'h2, {1'b0, 3'h6, s, 3'h4}));
		chk("film check", fc[15:0], 16'h0001);
		det.film = 1'b0;
		det.pwr = 1'b0;
		det.card = 1'b0;
		sens_in_fail = 1'b0;
		step(10);
		push_stop();
		look(M_CODE, ov(3'h3, 8'h00));
		push_stop();
		look(M_CODE, ov(3'h5, 8'h00));
		push_stop();
		look(M_CODE, ov(3'h5, 8'h00));
		card_swap = 1'b1;
		step(6);
		card_swap = 1'b0;
		step(10);
		look(M_CODE | M_SEL, ov(3'h7, 8'h00));
		mtest_done = 1'b1;
		mtest_fail = 1'b1;
		step(1);
		mtest_done = 1'b0;
		step(10);
		look(M_CODE | M_INH | M_SH | M_RUN | M_ST, ov(3'h1, 8'h01) | 16'h0400);
		for (int i = 0; i < 3; i++) begin
			look(M_SEL, 16'h4000);
			step(3);
		end
		push_stop();
		look(M_CODE | M_INH, ov(3'h1, 8'h00) | 16'h0400);
		det.pmem = 1'b1;
		step(10);
		look(M_CODE | M_ST | M_INH, ov(3'h0, 8'h03) | 16'h0400);
		rst_b = 1'b0;
		det.pmem = 1'b0;
		step(12);
		rst_b = 1'b1;
		mtest_done = 1'b1;
		step(1);
		mtest_done = 1'b0;
		step(10);
		look(M_CODE | M_ST, ov(3'h1, 8'h01));
		rst_b = 1'b0;
		mtest_fail = 1'b0;
		step(12);
		rst_b = 1'b1;
		mtest_done = 1'b1;
		step(1);
		mtest_done = 1'b0;
		step(10);
		look(M_CODE | M_ST | M_INH, ov(3'h7, 8'h00));
		give_verdict();
	end
endmodule : fsv_top_tb
